// ==== inc/adsc_pkg.sv ====
// ==========================================================================
// shared constants and types of the converter sequence control
// ==========================================================================
package adsc_pkg;

  // ========================================================================
  // register byte offsets on the bus
  // ========================================================================
  localparam logic [3:0] ADDR_CTRL_ONE  = 4'h0;  // converter_control_one
  localparam logic [3:0] ADDR_CTRL_TWO  = 4'h4;  // converter_control_two
  localparam logic [3:0] ADDR_RES_LOW   = 4'h8;  // result_low_reg
  localparam logic [3:0] ADDR_RES_HIGH  = 4'hc;  // result_high_reg
  localparam int         ADDR_W         = 4;     // decoded address bits

  // ========================================================================
  // field positions
  // ========================================================================
  localparam int C1_START_BIT  = 7;  // start_trigger
  localparam int C1_MODE_LSB   = 5;  // op_mode_select, two bits
  localparam int C1_AIN_EN_BIT = 4;  // analog_input_enable
  localparam int C1_CHAN_LSB   = 0;  // channel_select, four bits
  localparam int C2_DONE_BIT   = 7;  // conv_done_flag
  localparam int C2_BUSY_BIT   = 6;  // conv_busy_flag
  localparam int C2_TIME_LSB   = 0;  // conversion time code, three bits
  localparam int LOW_W         = 8;  // result bits held in the low register
  localparam int RESULT_W      = 10; // full result width
  localparam int HIGH_W        = RESULT_W - LOW_W;
  localparam int CHAN_W        = 4;
  localparam int TIME_W        = 3;
  localparam int CNT_MIN_W     = 11; // counter width needed for the longest time
  localparam int HTRANS_ACT    = 1;  // htrans bit set for NONSEQ and SEQ

  // ========================================================================
  // mode and channel codes, reset values
  // ========================================================================
  localparam logic [1:0]        MODE_OFF     = 2'h0;
  localparam logic [1:0]        MODE_SINGLE  = 2'h1;
  localparam logic [1:0]        MODE_REPEAT  = 2'h3;
  localparam logic [CHAN_W-1:0] CHAN_LAST    = 4'h7;  // analog_in_last
  localparam logic [TIME_W-1:0] TIME_MAX     = 3'h5;  // last valid time code
  localparam logic [10:0]       BASE_CYCLES  = 11'h027; // 39 clock periods
  localparam logic [31:0]       RD_ZERO      = 32'h0000_0000;

  // ========================================================================
  // types
  // ========================================================================
  // one register access handed from the bus slave to the block
  typedef struct packed {
    logic              wr;     // write strobe, one cycle
    logic              rd;     // read strobe, one cycle
    logic [ADDR_W-1:0] addr;   // byte offset
    logic [31:0]       wdata;  // write data
  } adsc_req_t;

  // bus slave state
  typedef struct packed {
    logic              wr_pend;  // write data phase in progress
    logic              rd_pend;  // read data phase, wait cycle
    logic [ADDR_W-1:0] addr;     // latched address
    logic [31:0]       rdata;    // registered read data
  } adsc_slv_state_t;

  // sequencer states, one-hot
  typedef enum logic [1:0] {
    CS_IDLE = 2'b01,
    CS_RUN  = 2'b10
  } adsc_fsm_t;

  // sequencer state
  typedef struct packed {
    adsc_fsm_t           fsm;       // idle or converting
    logic                start;     // start_trigger
    logic [1:0]          mode;      // op_mode_select
    logic                ain_en;    // analog_input_enable
    logic [CHAN_W-1:0]   chan;      // channel_select
    logic [TIME_W-1:0]   time_code; // conversion time code
    logic                done;      // conv_done_flag
    logic                low_read;  // low half read, high half not yet
    logic [RESULT_W-1:0] result;    // stored result
  } adsc_state_t;

  // timer state
  typedef struct packed {
    logic        running;  // counting a conversion
    logic [15:0] count;    // cycles left, upper bits unused at default width
  } adsc_tmr_state_t;

  // ========================================================================
  // conversion length in clock periods for a time code
  // ========================================================================
  function automatic logic [10:0] conv_cycles(input logic [TIME_W-1:0] code);
    logic [TIME_W-1:0] c;
    c = (code > TIME_MAX) ? TIME_MAX : code;  // reserved codes take the longest
    conv_cycles = BASE_CYCLES << c;
  endfunction

endpackage

// ==== rtl/adsc_ahb_slave.sv ====
`timescale 1ns/1ns
// ==========================================================================
// ahb-lite slave: writes take no wait, reads one wait state
// ==========================================================================
module adsc_ahb_slave (
  input  wire logic               clk,        // system clock
  input  wire logic               arst_n,     // async reset, active low
  input  wire logic               ce,         // clock enable
  input  wire logic               hsel,       // slave select
  input  wire logic [31:0]        haddr,      // address
  input  wire logic [1:0]         htrans,     // transfer type
  input  wire logic               hwrite,     // write not read
  input  wire logic [31:0]        hwdata,     // write data
  input  wire logic               hready,     // bus ready
  output logic                    hreadyout,  // slave ready
  output logic [31:0]             hrdata,     // read data
  output logic                    hresp,      // always okay
  output adsc_pkg::adsc_req_t     req,        // register access
  input  wire logic [31:0]        rd_data     // register read mux
);

  adsc_pkg::adsc_slv_state_t s;       // registered state
  adsc_pkg::adsc_slv_state_t next_s;  // next state

  // ========================================================================
  // next state and strobes
  // ========================================================================
  always_comb begin
    next_s    = s;
    req       = '0;
    hreadyout = ~s.rd_pend;  // reads stall one cycle so earlier writes settle
    hresp     = 1'b0;
    hrdata    = s.rdata;
    // write data phase: data stands now
    if (s.wr_pend) begin
      req.wr     = ce;
      req.addr   = s.addr;
      req.wdata  = hwdata;
      next_s.wr_pend = 1'b0;
    end
    // read wait cycle: sample the mux, read side effects fire here
    if (s.rd_pend) begin
      req.rd      = ce;
      req.addr    = s.addr;
      next_s.rdata   = rd_data;
      next_s.rd_pend = 1'b0;
    end
    // address phase taken
    if (hsel && hready && htrans[adsc_pkg::HTRANS_ACT]) begin
      next_s.wr_pend = hwrite;
      next_s.rd_pend = ~hwrite;
      next_s.addr    = haddr[adsc_pkg::ADDR_W-1:0];
    end
  end

  // ========================================================================
  // state register
  // ========================================================================
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      s <= '0;
    end else if (ce) begin
      s <= next_s;
    end
  end

endmodule

// ==== rtl/adsc_conv_timer.sv ====
`timescale 1ns/1ns
// ==========================================================================
// conversion length counter
// ==========================================================================
module adsc_conv_timer #(
  parameter int CNT_W = 11  // counter width
) (
  input  wire logic                          clk,        // system clock
  input  wire logic                          arst_n,     // async reset, active low
  input  wire logic                          ce,         // clock enable
  input  wire logic                          start,      // load and run
  input  wire logic                          abort,      // stop at once
  input  wire logic [adsc_pkg::TIME_W-1:0]   time_code,  // conversion time code
  output logic                               done,       // last cycle of conversion
  output logic                               running     // counting
);

  // elaboration check on the counter width
  if (CNT_W < adsc_pkg::CNT_MIN_W || CNT_W > 16) begin : g_bad_width
    $error("adsc_conv_timer: CNT_W out of range");
  end

  adsc_pkg::adsc_tmr_state_t s;       // registered state
  adsc_pkg::adsc_tmr_state_t next_s;  // next state

  // ========================================================================
  // count down; done flags the cycle whose edge ends the conversion
  // ========================================================================
  always_comb begin
    next_s  = s;
    running = s.running;
    done    = ce && s.running && (s.count == 16'h0001);  // abort is resolved by the caller
    if (s.running) begin
      next_s.count = s.count - 16'h0001;
      if (done) begin
        next_s.running = 1'b0;  // a restart below overrides this
      end
    end
    if (start) begin
      next_s.running = 1'b1;
      next_s.count   = {5'h00, adsc_pkg::conv_cycles(time_code)};
    end
    if (abort) begin
      next_s = '0;
    end
  end

  // ========================================================================
  // state register
  // ========================================================================
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      s <= '0;
    end else if (ce) begin
      s <= next_s;
    end
  end

endmodule

// ==== rtl/adsc_top.sv ====
// The placing of the registers and the AHB-Lite register port were chosen for this implementation.
`timescale 1ns/1ns
// ==========================================================================
// converter sequence control, top level
// ==========================================================================

module adsc_top #(
  parameter int CNT_W = 11  // conversion counter width
) (
  input  wire logic                             CLK,           // system clock
  input  wire logic                             ARST_N,        // async reset, active low
  input  wire logic                             CE,            // clock enable
  // ahb-lite slave
  input  wire logic                             HSEL,          // slave select
  input  wire logic [31:0]                      HADDR,         // address
  input  wire logic [1:0]                       HTRANS,        // transfer type
  input  wire logic                             HWRITE,        // write not read
  input  wire logic [2:0]                       HSIZE,         // word only
  input  wire logic [31:0]                      HWDATA,        // write data
  input  wire logic                             HREADY,        // bus ready
  output logic                                  HREADYOUT,     // slave ready
  output logic [31:0]                           HRDATA,        // read data
  output logic                                  HRESP,         // always okay
  // system
  input  wire logic                             LOWPOWER,      // a low-power mode is active
  output logic                                  CONV_DONE_IRQ, // completion pulse
  // converter core and multiplexer
  output logic                                  CORE_START,    // conversion begins
  output logic                                  CORE_ABORT,    // conversion abandoned
  input  wire logic [adsc_pkg::RESULT_W-1:0]    CORE_RESULT,   // result at completion
  output logic [adsc_pkg::CHAN_W-2:0]           MUX_CHANNEL,   // selected input
  output logic                                  MUX_ENABLE,    // input switch closed
  output logic                                  AREF_ENABLE    // reference path connected
);

  // elaboration check on the counter width
  if (CNT_W < adsc_pkg::CNT_MIN_W) begin : g_bad_width
    $error("adsc_top: CNT_W too small for the longest conversion");
  end

  // ========================================================================
  // declarations
  // ========================================================================
  adsc_pkg::adsc_state_t s;          // registered state
  adsc_pkg::adsc_state_t next_s;     // next state
  adsc_pkg::adsc_req_t   req;        // register access from the bus
  logic [31:0]           rd_data;    // read mux
  logic                  tmr_start;  // load the timer
  logic                  tmr_abort;  // stop the timer
  logic                  tmr_done;   // conversion finishes at this edge
  logic                  tmr_run;    // timer counting, not read anywhere
  logic                  busy;       // conv_busy_flag
  logic                  chan_ok;    // channel code is a real input
  logic [1:0]            wr_mode;    // mode field of a control write

  // ========================================================================
  // bus slave
  // ========================================================================
  adsc_ahb_slave u_slave (
    .clk       (CLK),
    .arst_n    (ARST_N),
    .ce        (CE),
    .hsel      (HSEL),
    .haddr     (HADDR),
    .htrans    (HTRANS),
    .hwrite    (HWRITE),
    .hwdata    (HWDATA),
    .hready    (HREADY),
    .hreadyout (HREADYOUT),
    .hrdata    (HRDATA),
    .hresp     (HRESP),
    .req       (req),
    .rd_data   (rd_data)
  );

  // ========================================================================
  // conversion length timer
  // ========================================================================
  adsc_conv_timer #(
    .CNT_W (CNT_W)
  ) u_timer (
    .clk       (CLK),
    .arst_n    (ARST_N),
    .ce        (CE),
    .start     (tmr_start),
    .abort     (tmr_abort),
    .time_code (s.time_code),
    .done      (tmr_done),
    .running   (tmr_run)
  );

  // ========================================================================
  // status decode
  // ========================================================================
  assign busy    = (s.fsm == adsc_pkg::CS_RUN);
  assign chan_ok = (s.chan <= adsc_pkg::CHAN_LAST);
  assign wr_mode = req.wdata[adsc_pkg::C1_MODE_LSB +: 2];

  // ========================================================================
  // read mux, unused bits and unmapped offsets read zero
  // ========================================================================
  always_comb begin
    rd_data = adsc_pkg::RD_ZERO;
    case (req.addr)
      adsc_pkg::ADDR_CTRL_ONE: begin
        rd_data[adsc_pkg::C1_START_BIT]          = s.start;
        rd_data[adsc_pkg::C1_MODE_LSB +: 2]      = s.mode;
        rd_data[adsc_pkg::C1_AIN_EN_BIT]         = s.ain_en;
        rd_data[adsc_pkg::C1_CHAN_LSB +: adsc_pkg::CHAN_W] = s.chan;
      end
      adsc_pkg::ADDR_CTRL_TWO: begin
        rd_data[adsc_pkg::C2_DONE_BIT]           = s.done;
        rd_data[adsc_pkg::C2_BUSY_BIT]           = busy;
        rd_data[adsc_pkg::C2_TIME_LSB +: adsc_pkg::TIME_W] = s.time_code;
      end
      adsc_pkg::ADDR_RES_LOW: begin
        rd_data[adsc_pkg::LOW_W-1:0]             = s.result[adsc_pkg::LOW_W-1:0];
      end
      adsc_pkg::ADDR_RES_HIGH: begin
        rd_data[adsc_pkg::HIGH_W-1:0]            = s.result[adsc_pkg::RESULT_W-1:adsc_pkg::LOW_W];
      end
      default: begin
        rd_data = adsc_pkg::RD_ZERO;  // unmapped
      end
    endcase
  end

  // ========================================================================
  // sequencer next state
  // order: reads, conversion, writes, low power; later steps override
  // ========================================================================
  always_comb begin
    next_s        = s;
    tmr_start     = 1'b0;
    tmr_abort     = 1'b0;
    CONV_DONE_IRQ = 1'b0;

    // result reads drive the interlock
    if (req.rd) begin
      case (req.addr)
        adsc_pkg::ADDR_RES_LOW: begin
          next_s.low_read = 1'b1;
        end
        adsc_pkg::ADDR_RES_HIGH: begin
          next_s.low_read = 1'b0;
          next_s.done     = 1'b0;
        end
        default: begin
          next_s.low_read = s.low_read;
        end
      endcase
    end

    // conversion sequencing
    case (s.fsm)
      adsc_pkg::CS_IDLE: begin
        // begin on a pending start in single or repeat mode
        if (CE && s.start && (s.mode == adsc_pkg::MODE_SINGLE || s.mode == adsc_pkg::MODE_REPEAT)) begin
          next_s.start = 1'b0;
          next_s.fsm   = adsc_pkg::CS_RUN;
          next_s.done  = 1'b0;
          tmr_start    = 1'b1;
        end
      end
      adsc_pkg::CS_RUN: begin
        if (tmr_done) begin
          // store unless the low half was read and the high half not yet
          if (!s.low_read) begin
            next_s.result = CORE_RESULT;
            next_s.done   = 1'b1;
            CONV_DONE_IRQ = 1'b1;
          end else begin
            next_s.result = s.result;
          end
          if (s.mode == adsc_pkg::MODE_REPEAT) begin
            tmr_start = 1'b1;
          end else begin
            next_s.fsm = adsc_pkg::CS_IDLE;
          end
        end
      end
      default: begin
        next_s.fsm = adsc_pkg::CS_IDLE;
      end
    endcase

    // register writes
    if (req.wr) begin
      case (req.addr)
        adsc_pkg::ADDR_CTRL_ONE: begin
          next_s.start  = req.wdata[adsc_pkg::C1_START_BIT];
          next_s.mode   = wr_mode;
          next_s.ain_en = req.wdata[adsc_pkg::C1_AIN_EN_BIT];
          next_s.chan   = req.wdata[adsc_pkg::C1_CHAN_LSB +: adsc_pkg::CHAN_W];
          // forced stop and disable
          if (wr_mode == adsc_pkg::MODE_OFF) begin
            next_s.fsm      = adsc_pkg::CS_IDLE;
            next_s.start    = 1'b0;
            next_s.done     = 1'b0;
            next_s.low_read = 1'b0;
            next_s.result   = '0;
            tmr_abort       = 1'b1;
            tmr_start       = 1'b0;
            CONV_DONE_IRQ   = 1'b0;
          end
        end
        adsc_pkg::ADDR_CTRL_TWO: begin
          next_s.time_code = req.wdata[adsc_pkg::C2_TIME_LSB +: adsc_pkg::TIME_W];
        end
        default: begin
          next_s.time_code = next_s.time_code;  // read-only or unmapped
        end
      endcase
    end

    // low-power entry clears everything but the time code and channel
    if (LOWPOWER) begin
      next_s           = '0;
      next_s.fsm       = adsc_pkg::CS_IDLE;
      next_s.time_code = s.time_code;
      next_s.chan      = s.chan;              // channel select is kept
      tmr_abort        = 1'b1;
      tmr_start        = 1'b0;
      CONV_DONE_IRQ    = 1'b0;
    end
  end

  // ========================================================================
  // core strobes
  // ========================================================================
  assign CORE_START = CE && tmr_start;
  assign CORE_ABORT = CE && tmr_abort && busy;

  // ========================================================================
  // multiplexer and reference, decoded from flip-flops, reference also gated by the LOWPOWER input
  // ========================================================================
  assign MUX_CHANNEL = s.chan[adsc_pkg::CHAN_W-2:0];
  assign MUX_ENABLE  = s.ain_en && chan_ok;
  assign AREF_ENABLE = busy && !LOWPOWER;

  // ========================================================================
  // state register
  // ========================================================================
  always_ff @(posedge CLK or negedge ARST_N) begin
    if (!ARST_N) begin
      s     <= '0;
      s.fsm <= adsc_pkg::CS_IDLE;
    end else if (CE) begin
      s <= next_s;
    end
  end

endmodule

// ==== test/adsc_top_chk.sv ====
`timescale 1ns/1ns
// ==========================================
// port checker of the sequence control
module adsc_top_chk #(parameter int CNT_W = 11) (
  input wire logic       CLK, ARST_N, HSEL, HWRITE, HREADY, HREADYOUT, HRESP, LOWPOWER,
  input wire logic [1:0] HTRANS,
  input wire logic       CONV_DONE_IRQ, CORE_START, CORE_ABORT, AREF_ENABLE
);
  default clocking @(posedge CLK); endclocking
  default disable iff (!ARST_N);
  sequence s_rd; HSEL && HREADY && HTRANS[1] && !HWRITE; endsequence
  sequence s_wait; !HREADYOUT ##1 HREADYOUT; endsequence
  a_read_wait_state: assert property (s_rd |=> s_wait) else $error("read wait state wrong");
  a_write_no_wait: assert property (HSEL && HREADY && HTRANS[1] && HWRITE |=> HREADYOUT)
    else $error("write stalled");
  a_resp_okay: assert property (!HRESP) else $error("error response");
  a_irq_one_cycle: assert property (CONV_DONE_IRQ |=> !CONV_DONE_IRQ) else $error("irq too long");
  a_conv_min_len: assert property (CORE_START |=> !CONV_DONE_IRQ [*8]) else $error("conversion short");
  a_start_sets_busy: assert property (CORE_START |=> AREF_ENABLE || LOWPOWER) else $error("no busy");
  a_lowpower_ref_off: assert property (LOWPOWER |-> !AREF_ENABLE && !CORE_START) else $error("ref on");
  a_no_auto_resume: assert property ($fell(LOWPOWER) |-> !CORE_START [*2]) else $error("resumed");
  a_abort_no_store: assert property (CORE_ABORT |-> !CONV_DONE_IRQ) else $error("stored on stop");
endmodule
bind adsc_top adsc_top_chk #(.CNT_W(CNT_W)) u_chk (.CLK, .ARST_N, .HSEL, .HWRITE, .HREADY, .HREADYOUT,
  .HRESP, .LOWPOWER, .HTRANS, .CONV_DONE_IRQ, .CORE_START, .CORE_ABORT, .AREF_ENABLE);

// ==== test/adsc_core_model.sv ====
`timescale 1ns/1ns
// ==========================================
// converter core stand-in, new sample per start
module adsc_core_model (
  input wire logic   CLK,
  input wire logic   ARST_N,
  input wire logic   CORE_START,
  input wire logic   CORE_ABORT,
  output logic [9:0] CORE_RESULT,
  output logic [9:0] SAMPLE
);
  logic run;  // set at a start, cleared by an abort or a reset
  // lfsr step as each conversion begins
  always @(posedge CLK or negedge ARST_N) begin
    if (!ARST_N) begin
      SAMPLE <= 10'h2a5;
      run <= 1'b0;
    end else if (CORE_START) begin
      SAMPLE <= {SAMPLE[8:0], SAMPLE[9] ^ SAMPLE[6]};
      run <= 1'b1;
    end else if (CORE_ABORT) begin
      run <= 1'b0;
    end
  end
  // result inverted before the first start and after an abort
  assign CORE_RESULT = run ? SAMPLE : ~SAMPLE;
endmodule

// ==== test/adsc_top_tb.sv ====
`timescale 1ns/1ns
// ==========================================
// self-checking bench of the sequence control
module adsc_top_tb;
  logic CLK, ARST_N, LOWPOWER, HWRITE, HREADYOUT, HRESP, CONV_DONE_IRQ, CORE_START, CORE_ABORT;
  logic MUX_ENABLE, AREF_ENABLE;
  logic [1:0] HTRANS;
  logic [2:0] MUX_CHANNEL;
  logic [31:0] HADDR, HWDATA, HRDATA;
  logic [9:0] CORE_RESULT, SAMPLE, last, saved;
  int num_errors = 0, n_compared = 0, seed = 19472, cyc = 0, lat = 0, nirq = 0, n0, ch;
  adsc_top u_adsc_top (.CLK, .ARST_N, .CE(1'b1), .HSEL(1'b1), .HADDR, .HTRANS, .HWRITE, .HSIZE(3'h2),
    .HWDATA, .HREADY(HREADYOUT), .HREADYOUT, .HRDATA, .HRESP, .LOWPOWER, .CONV_DONE_IRQ, .CORE_START,
    .CORE_ABORT, .CORE_RESULT, .MUX_CHANNEL, .MUX_ENABLE, .AREF_ENABLE);
  adsc_core_model u_adsc_core_model (.CLK, .ARST_N, .CORE_START, .CORE_ABORT, .CORE_RESULT, .SAMPLE);
  initial begin
    CLK = 1'b0;
    forever #2 CLK = ~CLK;
  end
  // model: cycles since start, completions, latest sample
  always @(posedge CLK) begin
    cyc <= (CORE_START === 1'b1) ? 1 : cyc + 1;
    if (CONV_DONE_IRQ === 1'b1) begin
      lat <= cyc;
      nirq <= nirq + 1;
      last <= SAMPLE;
    end
  end
  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    n_compared++;
    if (g !== e) begin
      num_errors++;
      $display("MISMATCH %s exp %h got %h", nm, e, g);
    end
  endtask
  // one ahb-lite single transfer
  task automatic bus(input logic w, input logic [3:0] a, input logic [31:0] d, output logic [31:0] r);
    HADDR <= {28'h0, a};
    HWRITE <= w;
    HTRANS <= 2'h2;
    do @(posedge CLK); while (HREADYOUT !== 1'b1);
    HTRANS <= 2'h0;
    HWDATA <= d;
    do @(posedge CLK); while (HREADYOUT !== 1'b1);
    r = HRDATA;
  endtask
  task automatic wr(input logic [3:0] a, input logic [31:0] d);
    logic [31:0] r;
    bus(1'b1, a, d, r);
  endtask
  task automatic rd(input logic [3:0] a, input logic [31:0] e, input string nm);
    logic [31:0] r;
    bus(1'b0, a, 32'h0, r);
    chk(nm, e, r);
  endtask
  task automatic wait_irq(input int k);
    int t;
    for (int i = 0; i < k; i++) begin
      n0 = nirq;
      t = 0;
      while (nirq == n0 && t < 3000) begin
        @(posedge CLK);
        t++;
      end
      chk("irq", 32'(n0 + 1), 32'(nirq));
    end
    @(posedge CLK);
  endtask
  task automatic end_of_test;
    $display("compared %0d mismatches %0d", n_compared, num_errors);
    if (num_errors == 0 && n_compared > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask
  initial begin
    #100000;
    num_errors++;
    end_of_test;
  end
  initial begin
    {ARST_N, LOWPOWER, HWRITE, HTRANS, HADDR, HWDATA} = '0;
    repeat (12) @(posedge CLK);
    ARST_N <= 1'b1;
    @(posedge CLK);
    rd(adsc_pkg::ADDR_CTRL_TWO, 32'h0, "ctrl_two reset");
    // single conversions over every time code
    for (int tc = 0; tc < 8; tc++) begin
      ch = $random(seed) & 7;
      wr(adsc_pkg::ADDR_CTRL_TWO, tc);
      wr(adsc_pkg::ADDR_CTRL_ONE, 32'h30 | ch);
      wr(adsc_pkg::ADDR_CTRL_ONE, 32'hb0 | ch);
      rd(adsc_pkg::ADDR_CTRL_ONE, 32'h30 | ch, "start");
      chk("mux", ch + 8, 32'({MUX_ENABLE, MUX_CHANNEL}));
      rd(adsc_pkg::ADDR_CTRL_TWO, 32'h40 | tc, "busy");
      wait_irq(1);
      chk("latency", 32'(adsc_pkg::BASE_CYCLES) << ((tc > 5) ? 5 : tc), 32'(lat));
      rd(adsc_pkg::ADDR_CTRL_TWO, 32'h80 | tc, "done");
      rd(adsc_pkg::ADDR_RES_LOW, 32'(last[7:0]), "low");
      rd(adsc_pkg::ADDR_RES_HIGH, 32'(last[9:8]), "high");
      rd(adsc_pkg::ADDR_CTRL_TWO, tc, "done clear");
    end
    $display("single test done");
    wr(adsc_pkg::ADDR_CTRL_TWO, 32'h0);
    wr(adsc_pkg::ADDR_CTRL_ONE, 32'hb2);
    wait_irq(1);
    saved = last;
    wr(adsc_pkg::ADDR_CTRL_ONE, 32'hb2);
    rd(adsc_pkg::ADDR_CTRL_TWO, 32'h40, "restart done");
    rd(adsc_pkg::ADDR_RES_LOW, 32'(saved[7:0]), "old low");
    rd(adsc_pkg::ADDR_RES_HIGH, 32'(saved[9:8]), "old high");
    wait_irq(1);
    wr(adsc_pkg::ADDR_CTRL_ONE, 32'hf3);
    wait_irq(2);
    chk("repeat gap", 32'h27, 32'(lat));
    saved = last;
    rd(adsc_pkg::ADDR_RES_LOW, 32'(saved[7:0]), "low held");
    n0 = nirq;
    repeat (60) @(posedge CLK);
    chk("irq dropped", 32'(n0), 32'(nirq));
    rd(adsc_pkg::ADDR_RES_HIGH, 32'(saved[9:8]), "high held");
    wait_irq(1);
    wr(adsc_pkg::ADDR_CTRL_ONE, 32'h13);
    rd(adsc_pkg::ADDR_CTRL_TWO, 32'h0, "stop flags");
    rd(adsc_pkg::ADDR_RES_LOW, 32'h0, "stop result");
    n0 = nirq;
    repeat (60) @(posedge CLK);
    chk("stopped", 32'(n0), 32'(nirq));
    $display("repeat test done");
    wr(adsc_pkg::ADDR_CTRL_ONE, 32'hf5);
    repeat (50) @(posedge CLK);
    chk("ref on", 32'h1, 32'(AREF_ENABLE));
    LOWPOWER <= 1'b1;
    repeat (3) @(posedge CLK);
    chk("ref off", 32'h0, 32'(AREF_ENABLE));
    LOWPOWER <= 1'b0;
    n0 = nirq;
    rd(adsc_pkg::ADDR_CTRL_ONE, 32'h5, "lp ctrl");
    rd(adsc_pkg::ADDR_CTRL_TWO, 32'h0, "lp flags");
    rd(adsc_pkg::ADDR_RES_LOW, 32'h0, "lp result");
    repeat (60) @(posedge CLK);
    chk("no resume", 32'(n0), 32'(nirq));
    wr(adsc_pkg::ADDR_CTRL_ONE, 32'h1c);
    @(posedge CLK);
    chk("mux reserved", 32'h4, 32'({MUX_ENABLE, MUX_CHANNEL}));
    $display("lowpower test done");
    end_of_test;
  end
endmodule
